// >>> rtl/wdt_pkg.sv
/*
  constants, field layout and types shared by the watchdog unit one
  control logic: register offsets, control bits, keys, divider taps
  and reset pulse lengths.
  assumes a single 50 mhz system clock domain.
*/
`default_nettype none
package wdt_pkg;
  // apb register byte addresses
  localparam int ADDR_W = 12;
  localparam logic [11:0] CTRL_ADDR = 12'h000;
  localparam logic [11:0] COUNT_ADDR = 12'h004;
  localparam logic [11:0] IRQ_STATUS_ADDR = 12'h008;
  localparam logic [11:0] IRQ_CLEAR_ADDR = 12'h00c;
  localparam logic [11:0] IRQ_ENABLE_ADDR = 12'h010;
  // keys in the upper byte of a shared-address write
  localparam logic [7:0] KEY_COUNT = 8'h5a;
  localparam logic [7:0] KEY_STATUS = 8'ha5;
  localparam int KEY_LSB = 8;
  // watchdog_control_status field positions
  localparam int WRAP_BIT = 7;
  localparam int MODE_BIT = 6;
  localparam int ENABLE_BIT = 5;
  localparam int PSS_BIT = 4;
  localparam int ACTION_BIT = 3;
  localparam int CKS_LSB = 0;
  localparam int CKS_W = 3;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hff;
  // interrupt event bits
  localparam int EV_W = 3;
  localparam int EV_WRAP = 0;
  localparam int EV_NMI = 1;
  localparam int EV_RESET = 2;
  localparam logic [2:0] EV_RESET_VAL = 3'h0;
  // prescaler taps, log2 of the divide ratio per clock select code
  localparam int MAIN_W = 17;
  localparam int SUB_W = 8;
  localparam int MAIN_LOG2 [8] = '{1, 6, 7, 9, 11, 13, 15, 17};
  localparam int SUB_LOG2 [8] = '{1, 2, 3, 4, 5, 6, 7, 8};
  // overflow reset pulse lengths in system clocks
  localparam int PULSE_W = 10;
  localparam logic [9:0] RESET_CLOCKS = 10'd518;
  localparam logic [9:0] RESET_OUT_STATES = 10'd132;
  typedef enum logic {PULSE_IDLE, PULSE_ACTIVE} pulse_state_t;
endpackage
`default_nettype wire

// >>> rtl/wdt_link_if.sv
/*
  signals between the control core and its two helpers: prescaler tap
  selection with the resulting tick, and the overflow reset pulse.
  assumes all parties run on sys_clk.
*/
`default_nettype none
interface wdt_link_if;
  logic source_select;
  logic [2:0] clock_select;
  logic tick;
  logic reset_start;
  logic internal_reset;
  logic reset_out_n;
  modport prescale (input source_select, input clock_select,
    output tick);
  modport pulse (input reset_start, output internal_reset,
    output reset_out_n);
  modport core (output source_select, output clock_select,
    input tick, output reset_start, input internal_reset,
    input reset_out_n);
endinterface
`default_nettype wire

// >>> rtl/wdt_prescaler.sv
/*
  main-clock and sub-clock prescalers for watchdog unit one; emits a
  one-cycle tick at the selected tap.
  assumes sub_clk_pin is an asynchronous 32.768 khz level and that
  sys_clk is far faster than it.
*/
`default_nettype none
module wdt_prescaler
  import wdt_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic ce,
  // sub-clock pin
  input wire logic sub_clk_pin,
  // tap selection
  wdt_link_if.prescale link
);
  logic sync1, sync2, sync3, sub_level, sub_rise;
  logic [MAIN_W-1:0] main_count;
  logic [SUB_W-1:0] sub_count;
  logic [7:0] main_tap, sub_tap;

  // three-stage synchroniser; only agreeing late stages are trusted
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
    end else if (ce) begin
      sync1 <= sub_clk_pin;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  assign sub_rise = sync2 & sync3 & ~sub_level;

  // filtered sub-clock level, follows only agreed changes
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sub_level <= 1'b0;
    end else if (ce && sync2 == sync3) begin
      sub_level <= sync3;
    end
  end

  // free-running dividers; taps are never cleared, so a tap change
  // while counting gives one short first interval
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      main_count <= '0;
      sub_count <= '0;
    end else if (ce) begin
      main_count <= main_count + 1'b1;
      if (sub_rise) begin
        sub_count <= sub_count + 1'b1;
      end
    end
  end

  // one tap per clock select code
  for (genvar i = 0; i < 8; i++) begin : g_tap
    assign main_tap[i] = &main_count[MAIN_LOG2[i]-1:0];
    assign sub_tap[i] = sub_rise & (&sub_count[SUB_LOG2[i]-1:0]);
  end

  // registered tick from the chosen prescaler
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      link.tick <= 1'b0;
    end else if (ce) begin
      link.tick <= link.source_select ? sub_tap[link.clock_select]
                                      : main_tap[link.clock_select];
    end
  end
endmodule
`default_nettype wire

// >>> rtl/wdt_reset_pulse.sv
/*
  stretches an overflow reset request into the internal reset and the
  reset output pin pulse.
  assumes reset_start is a one-cycle pulse on sys_clk.
*/
`default_nettype none
module wdt_reset_pulse
  import wdt_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic ce,
  // pulse group
  wdt_link_if.pulse link
);
  pulse_state_t state;
  logic [PULSE_W-1:0] elapsed;

  // a new request during a pulse is absorbed: the chip is resetting
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state <= PULSE_IDLE;
      elapsed <= '0;
    end else if (ce) begin
      unique case (state)
        PULSE_IDLE: begin
          elapsed <= '0;
          if (link.reset_start) begin
            state <= PULSE_ACTIVE;
          end
        end
        PULSE_ACTIVE: begin
          elapsed <= elapsed + 1'b1;
          if (elapsed == RESET_CLOCKS - 1'b1) begin
            state <= PULSE_IDLE;
          end
        end
      endcase
    end
  end

  // both outputs start together on the first active cycle
  assign link.internal_reset = (state == PULSE_ACTIVE);
  assign link.reset_out_n = ~((state == PULSE_ACTIVE) &&
                              (elapsed < RESET_OUT_STATES));
endmodule
`default_nettype wire

// >>> rtl/wdt_unit_one.sv
/*
  watchdog timer unit one: apb register slave, 8-bit up-counter,
  control/status register, overflow actions and interrupt block.
  assumes an apb3 master on sys_clk, an asynchronous sub-clock pin,
  and a system that honours internal_reset and nmi_request.
*/
`default_nettype none
module wdt_unit_one
  import wdt_pkg::*;
(
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [wdt_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // sub-clock pin
  input wire logic sub_clk_pin,
  // overflow actions
  output logic interval_overflow_interrupt,
  output logic nmi_request,
  output logic internal_reset,
  output logic reset_out_n,
  // combined interrupt
  output logic irq
);
  import wdt_pkg::*;

  wdt_link_if link ();

  logic wrap_flag, timer_mode_select, count_enable;
  logic prescaler_source_select, overflow_action;
  logic [CKS_W-1:0] clock_select;
  logic [7:0] watchdog_count;
  logic read_armed;
  logic [EV_W-1:0] irq_status, irq_enable, events;
  logic access, mapped, setup;
  logic wr_shared, wr_count, wr_status;
  logic status_read, flag_clear, wrap;
  logic [7:0] status_view;
  logic [7:0] key, payload;
  logic [31:0] next_rdata;

  wdt_prescaler u_prescaler (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .ce(ce),
    .sub_clk_pin(sub_clk_pin),
    .link(link.prescale)
  );

  wdt_reset_pulse u_reset_pulse (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .ce(ce),
    .link(link.pulse)
  );

  // the helpers only see the selection fields
  assign link.source_select = prescaler_source_select;
  assign link.clock_select = clock_select;

  // apb decode; zero wait states, but a frozen block stalls the bus
  assign setup = psel & ~penable;
  assign access = psel & penable & ce;
  assign pready = ce;
  assign mapped = (paddr == CTRL_ADDR) || (paddr == COUNT_ADDR) ||
                  (paddr == IRQ_STATUS_ADDR) ||
                  (paddr == IRQ_CLEAR_ADDR) ||
                  (paddr == IRQ_ENABLE_ADDR);
  assign pslverr = psel & penable & ~mapped;

  // keyed shared-address write, key upper byte, data lower
  assign key = pwdata[KEY_LSB +: 8];
  assign payload = pwdata[7:0];
  assign wr_shared = access & pwrite & (paddr == CTRL_ADDR);
  assign wr_count = wr_shared & (key == KEY_COUNT);
  assign wr_status = wr_shared & (key == KEY_STATUS);
  assign status_read = access & ~pwrite & (paddr == CTRL_ADDR);

  assign status_view = {wrap_flag, timer_mode_select, count_enable,
                        prescaler_source_select, overflow_action,
                        clock_select};

  // read data captured in the setup cycle, steady through access
  always_comb begin
    next_rdata = '0;
    unique case (paddr)
      CTRL_ADDR: next_rdata[7:0] = status_view;
      COUNT_ADDR: next_rdata[7:0] = watchdog_count;
      IRQ_STATUS_ADDR: next_rdata[EV_W-1:0] = irq_status;
      IRQ_ENABLE_ADDR: next_rdata[EV_W-1:0] = irq_enable;
      default: next_rdata = '0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      prdata <= '0;
    end else if (ce && setup && !pwrite) begin
      prdata <= next_rdata;
    end
  end

  // control fields; keyless or wrongly keyed writes are dropped
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      timer_mode_select <= CTRL_RESET[MODE_BIT];
      count_enable <= CTRL_RESET[ENABLE_BIT];
      prescaler_source_select <= CTRL_RESET[PSS_BIT];
      overflow_action <= CTRL_RESET[ACTION_BIT];
      clock_select <= CTRL_RESET[CKS_LSB +: CKS_W];
    end else if (ce && wr_status) begin
      timer_mode_select <= payload[MODE_BIT];
      count_enable <= payload[ENABLE_BIT];
      prescaler_source_select <= payload[PSS_BIT];
      overflow_action <= payload[ACTION_BIT];
      clock_select <= payload[CKS_LSB +: CKS_W];
    end
  end

  // wrap detection: only a real tick at ff wraps, not a write
  assign wrap = count_enable & link.tick & ~wr_count &
                (watchdog_count == COUNT_MAX);

  // counter; a write wins over a coincident tick
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      watchdog_count <= COUNT_RESET;
    end else if (ce) begin
      if (!count_enable) begin
        watchdog_count <= COUNT_RESET;
      end else if (wr_count) begin
        watchdog_count <= payload;
      end else if (link.tick) begin
        watchdog_count <= watchdog_count + 1'b1;
      end
    end
  end

  // a status read that sees the flag set arms the clearing write;
  // the arm is spent by any keyed status write
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      read_armed <= 1'b0;
    end else if (ce) begin
      if (status_read && wrap_flag) begin
        read_armed <= 1'b1;
      end else if (wr_status || !wrap_flag) begin
        read_armed <= 1'b0;
      end
    end
  end

  // writing one to the flag position never sets it
  assign flag_clear = (wr_status & ~payload[WRAP_BIT] & read_armed) |
                      (wr_status & ~payload[ENABLE_BIT]) |
                      link.internal_reset;

  // overflow flag; a wrap in the clearing cycle wins
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wrap_flag <= CTRL_RESET[WRAP_BIT];
    end else if (ce) begin
      if (wrap) begin
        wrap_flag <= 1'b1;
      end else if (flag_clear) begin
        wrap_flag <= 1'b0;
      end
    end
  end

  // overflow actions: interval request follows the flag directly
  assign interval_overflow_interrupt = wrap_flag & ~timer_mode_select;
  assign link.reset_start = wrap & timer_mode_select & overflow_action;
  assign internal_reset = link.internal_reset;
  assign reset_out_n = link.reset_out_n;

  // nmi request is a one-cycle registered pulse
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      nmi_request <= 1'b0;
    end else if (ce) begin
      nmi_request <= wrap & timer_mode_select & ~overflow_action;
    end
  end

  // event bits for the interrupt block
  assign events[EV_WRAP] = wrap;
  assign events[EV_NMI] = wrap & timer_mode_select & ~overflow_action;
  assign events[EV_RESET] = link.reset_start;

  // sticky status, write-one-to-clear; a new event beats the clear
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      irq_status <= EV_RESET_VAL;
    end else if (ce) begin
      if (access && pwrite && paddr == IRQ_CLEAR_ADDR) begin
        irq_status <= (irq_status & ~pwdata[EV_W-1:0]) | events;
      end else begin
        irq_status <= irq_status | events;
      end
    end
  end

  // interrupt enable register
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      irq_enable <= EV_RESET_VAL;
    end else if (ce && access && pwrite &&
                 paddr == IRQ_ENABLE_ADDR) begin
      irq_enable <= pwdata[EV_W-1:0];
    end
  end

  // level interrupt while any enabled status bit is set
  assign irq = |(irq_status & irq_enable);
endmodule
`default_nettype wire

// >>> testbench/wdt_unit_one_chk.sv
/*
  port-level checks for watchdog unit one.
  assumes one sys_clk domain and resetn async active low.
*/
`default_nettype none
module wdt_unit_one_chk (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic ce,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // overflow actions
  input wire logic interval_overflow_interrupt,
  input wire logic nmi_request,
  input wire logic internal_reset,
  input wire logic reset_out_n,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] hi_cnt;
  logic [9:0] lo_cnt;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // cycles the internal reset has been high so far
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) hi_cnt <= 10'h000;
    else if (internal_reset) hi_cnt <= hi_cnt + 10'h001;
    else hi_cnt <= 10'h000;
  end
  // cycles the pin has been low so far
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) lo_cnt <= 10'h000;
    else if (!reset_out_n) lo_cnt <= lo_cnt + 10'h001;
    else lo_cnt <= 10'h000;
  end
  sequence pulse_start;
    $rose(internal_reset) && !reset_out_n;
  endsequence
  sequence pulse_hold;
    (internal_reset && !reset_out_n) [*8];
  endsequence
  ready_follows_ce_a: assert property (pready == ce)
    else $error("pready differs from ce");
  err_in_access_a: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access");
  rdata_hold_a: assert property
    (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("prdata moved without read setup");
  pin_with_reset_a: assert property ($fell(reset_out_n) |-> pulse_start)
    else $error("pin low without reset start");
  pulse_steady_a: assert property (pulse_start |-> pulse_hold)
    else $error("reset pulse broke early");
  reset_len_a: assert property ($fell(internal_reset) |-> hi_cnt == 10'h206)
    else $error("internal reset length wrong");
  pin_len_a: assert property ($rose(reset_out_n) |-> lo_cnt == 10'h084)
    else $error("reset pin low length wrong");
  nmi_single_a: assert property (nmi_request |-> reset_out_n ##1 !nmi_request)
    else $error("nmi request not single");
  interval_quiet_a: assert property
    ($rose(interval_overflow_interrupt) |-> !nmi_request && !internal_reset)
    else $error("interval interrupt with watchdog action");
  quiet_in_reset_a: assert property (disable iff (1'b0)
    !resetn |-> !irq && !nmi_request && !internal_reset && reset_out_n)
    else $error("output active during reset");
endmodule
bind wdt_unit_one wdt_unit_one_chk chk_i (.sys_clk, .resetn, .ce, .psel,
  .penable, .pwrite, .prdata, .pready, .pslverr,
  .interval_overflow_interrupt, .nmi_request, .internal_reset,
  .reset_out_n, .irq);
`default_nettype wire

// >>> testbench/wdt_sys_model.sv
/*
  system side model: takes nmi pulses and the reset pulse and measures.
  assumes sys_clk; does not feed the reset back, so the bench can read on.
*/
`default_nettype none
module wdt_sys_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // overflow actions
  input wire logic nmi_request,
  input wire logic internal_reset,
  input wire logic reset_out_n,
  // what the system saw
  output var int nmi_seen,
  output var int rst_len,
  output var int low_len
);
  timeunit 1ns;
  timeprecision 1ps;
  int r;
  int l;
  // a stuck nmi would count more than once per overflow
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) nmi_seen <= 0;
    else if (nmi_request) nmi_seen <= nmi_seen + 1;
  end
  // lengths latch when each pulse ends
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      r <= 0;
      l <= 0;
      rst_len <= 0;
      low_len <= 0;
    end else begin
      r <= internal_reset ? r + 1 : 0;
      l <= !reset_out_n ? l + 1 : 0;
      if (!internal_reset && r != 0) rst_len <= r;
      if (reset_out_n && l != 0) low_len <= l;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/watchdog_timer_unit_one_control_tb_top.sv
/*
  register-level bench for watchdog unit one over apb.
  assumes ce high except in the frozen-block check, and the /2 main tap, so a wrap takes a few cycles.
*/
`default_nettype none
module watchdog_timer_unit_one_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import wdt_pkg::*;
  logic sys_clk, resetn, ce, psel, penable, pwrite, sub_clk_pin, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, interval_overflow_interrupt, irq;
  wire logic nmi_request, internal_reset, reset_out_n;
  int errors, n_checks, cyc, nmi_seen, rst_len, low_len;
  wdt_unit_one dut (.sys_clk, .resetn, .ce, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .sub_clk_pin,
    .interval_overflow_interrupt, .nmi_request, .internal_reset,
    .reset_out_n, .irq);
  wdt_sys_model sys_i (.sys_clk, .resetn, .nmi_request, .internal_reset,
    .reset_out_n, .nmi_seen, .rst_len, .low_len);
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task tally_and_finish;
    if (errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // a hang anywhere ends here
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      tally_and_finish;
    end
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one apb transfer; request held until pready is seen high
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdc(input logic [11:0] a, input string nm, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  task wk(input logic [7:0] key, input logic [7:0] v);
    bus(1'b1, CTRL_ADDR, {16'h0000, key, v});
  endtask
  initial begin
    {resetn, psel, penable, pwrite, sub_clk_pin} = 5'h00;
    ce = 1'b1;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    rdc(CTRL_ADDR, "ctrl", 32'h0);
    rdc(COUNT_ADDR, "count", 32'h0);
    bus(1'b0, 12'h0f0, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    // every tap code on both prescalers, counter stopped
    for (int i = 0; i < 16; i++) begin
      wk(KEY_STATUS, {3'h0, i[3], 1'b0, i[2:0]});
      rdc(CTRL_ADDR, "taps", {27'h0, i[3], 1'b0, i[2:0]});
    end
    wk(8'h3c, 8'h20);
    rdc(CTRL_ADDR, "bad key", 32'h17);
    // interval mode: wrap, flag, interrupt
    wk(KEY_STATUS, 8'h20);
    bus(1'b1, IRQ_ENABLE_ADDR, 32'h1);
    wk(KEY_COUNT, 8'hfe);
    @(posedge sys_clk iff interval_overflow_interrupt);
    chk("irq", 32'h1, {31'h0, irq});
    wk(KEY_STATUS, 8'h20);
    rdc(CTRL_ADDR, "unread", 32'ha0);
    wk(KEY_STATUS, 8'ha0);
    rdc(CTRL_ADDR, "one write", 32'ha0);
    rdc(CTRL_ADDR, "poll", 32'ha0);
    wk(KEY_STATUS, 8'h20);
    rdc(CTRL_ADDR, "cleared", 32'h20);
    bus(1'b1, IRQ_CLEAR_ADDR, 32'h1);
    #1 chk("irq clr", 32'h0, {31'h0, irq});
    // masked wrap, then stop the timer
    bus(1'b1, IRQ_ENABLE_ADDR, 32'h0);
    wk(KEY_COUNT, 8'hfe);
    @(posedge sys_clk iff interval_overflow_interrupt);
    #1 chk("irq mask", 32'h0, {31'h0, irq});
    wk(KEY_STATUS, 8'h00);
    rdc(CTRL_ADDR, "stop", 32'h0);
    rdc(COUNT_ADDR, "zeroed", 32'h0);
    // watchdog mode with nmi action
    wk(KEY_STATUS, 8'h60);
    wk(KEY_COUNT, 8'hfe);
    @(posedge sys_clk iff nmi_request);
    repeat (2) @(posedge sys_clk);
    chk("nmi", 32'h1, nmi_seen);
    chk("interval_overflow_interrupt", 32'h0, {31'h0, interval_overflow_interrupt});
    rdc(IRQ_STATUS_ADDR, "events", 32'h3);
    wk(KEY_STATUS, 8'h00);
    // watchdog mode with reset action
    wk(KEY_STATUS, 8'h68);
    wk(KEY_COUNT, 8'hfe);
    @(posedge sys_clk iff internal_reset);
    @(posedge sys_clk);
    rdc(CTRL_ADDR, "auto clr", 32'h68);
    wk(KEY_STATUS, 8'h48);
    @(posedge sys_clk iff !internal_reset);
    #1 chk("rst len", 32'd518, rst_len);
    chk("pin len", 32'd132, low_len);
    // sub prescaler /2: four pin rises give two ticks
    wk(KEY_STATUS, 8'h30);
    repeat (4) begin
      repeat (5) @(posedge sys_clk);
      sub_clk_pin <= 1'b1;
      repeat (5) @(posedge sys_clk);
      sub_clk_pin <= 1'b0;
    end
    repeat (5) @(posedge sys_clk);
    rdc(COUNT_ADDR, "sub count", 32'h2);
    // a frozen block must miss pin edges entirely
    @(posedge sys_clk);
    ce <= 1'b0;
    repeat (2) begin
      repeat (5) @(posedge sys_clk);
      sub_clk_pin <= 1'b1;
      repeat (5) @(posedge sys_clk);
      sub_clk_pin <= 1'b0;
    end
    @(posedge sys_clk);
    ce <= 1'b1;
    repeat (5) @(posedge sys_clk);
    rdc(COUNT_ADDR, "frozen", 32'h2);
    tally_and_finish;
  end
endmodule
`default_nettype wire
